// *** sfi_consts.vh ***
// constants for the sample flag insertion block
// assumes: included by bare name from the design files of this block
`ifndef SFI_CONSTS_VH
`define SFI_CONSTS_VH

// ----------------------------------------------------------------
// register word offsets (byte addresses)
// ----------------------------------------------------------------
`define SFI_REG_CTRL 8'h00
`define SFI_REG_THRESH 8'h04
`define SFI_REG_PERIOD 8'h08
`define SFI_REG_STATUS 8'h0C
`define SFI_REG_CLEAR 8'h10
`define SFI_REG_ENABLE 8'h14
`define SFI_REG_FLAGS 8'h18

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define SFI_CTRL_MARKER_EN 0
`define SFI_CTRL_SINGLE 1
`define SFI_CTRL_DECIM 2
`define SFI_CTRL_EIGHT_BIT 3
`define SFI_CTRL_W 4
`define SFI_CTRL_RST 4'h0

// ----------------------------------------------------------------
// threshold and period fields and reset values
// ----------------------------------------------------------------
`define SFI_THR_HI_LSB 0
`define SFI_THR_LO_LSB 8
`define SFI_THR_HI_RST 8'hE4
`define SFI_THR_LO_RST 8'h40
`define SFI_PER_W 4
`define SFI_PER_RST 4'h0

// ----------------------------------------------------------------
// status, clear and enable layout
// ----------------------------------------------------------------
`define SFI_ST_A_HI 0
`define SFI_ST_A_LO 1
`define SFI_ST_B_HI 2
`define SFI_ST_B_LO 3
`define SFI_ST_MARKER 4
`define SFI_ST_REFUSED 5
`define SFI_ST_W 6
`define SFI_ST_RST 6'h00

// ----------------------------------------------------------------
// widths and timing
// ----------------------------------------------------------------
`define SFI_SAMP_W 12
`define SFI_CPLX_W 16
`define SFI_MAG_TOP 8
`define SFI_WIN_W 17
`define SFI_MRK_LAT 2

`endif

// *** sfi_ovr_win.v ***
// windowed overrange detector for one converter channel
// assumes: one 12-bit two's complement sample per clock on sample
`timescale 1ns/1ns
`default_nettype none
`include "sfi_consts.vh"

module sfi_ovr_win (
  input wire clk,
  input wire reset_n,
  input wire [11:0] sample,
  input wire two_per_clk,
  input wire [7:0] thr_hi,
  input wire [7:0] thr_lo,
  input wire [3:0] period_exp,
  output reg hi_flag,
  output reg lo_flag
);

  // ----------------------------------------------------------------
  // magnitude of the sample, saturated at 2047
  // ----------------------------------------------------------------
  wire [10:0] neg_low = ~sample[10:0] + 11'h001;
  wire [10:0] mag = !sample[11] ? sample[10:0] :
    ((sample[10:0] == 11'h000) ? 11'h7FF : neg_low);
  wire [7:0] mag_top = mag[10:3]; // RL1
  wire hit_hi = (mag_top >= thr_hi); // RL1
  wire hit_lo = (mag_top >= thr_lo); // RL1

  // ----------------------------------------------------------------
  // window length of 2^exponent converter samples
  // ----------------------------------------------------------------
  wire [16:0] win_len = 17'h0_0001 << period_exp; // RL2
  wire [16:0] step = two_per_clk ? 17'h0_0002 : 17'h0_0001; // RL11
  reg [16:0] cnt_q;
  reg acc_hi_q;
  reg acc_lo_q;
  wire [16:0] cnt_next = cnt_q + step;
  wire win_end = (cnt_next >= win_len);

  // count window, gather hits, publish flags at window end
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q <= 17'h0_0000;
      acc_hi_q <= 1'b0;
      acc_lo_q <= 1'b0;
      hi_flag <= 1'b0;
      lo_flag <= 1'b0;
    end
    else if (win_end)
    begin
      cnt_q <= 17'h0_0000;
      acc_hi_q <= 1'b0; // RL12
      acc_lo_q <= 1'b0; // RL12
      hi_flag <= acc_hi_q | hit_hi; // RL2
      lo_flag <= acc_lo_q | hit_lo; // RL2
    end
    else
    begin
      cnt_q <= cnt_next;
      acc_hi_q <= acc_hi_q | hit_hi; // RL2
      acc_lo_q <= acc_lo_q | hit_lo; // RL2
    end
  end

endmodule // sfi_ovr_win

`default_nettype wire

// *** sfi_top.v ***
// sample flag insertion: overrange flags and marker bit in output samples
// assumes: samples arrive on clk, marker may be asynchronous; register port is a simple
// one-cycle strobe slave with read data one cycle after the read strobe
//
// Operation
// RL1 - compare top 8 bits of sample magnitude against both thresholds, equal counts
// RL2 - flag set if threshold exceeded anywhere in a 2^exponent sample window
// RL3 - dual complex mode: high flag in I, low flag in Q, per channel
// RL4 - embedded flag: keep upper 15 bits, flag in the LSB
// RL5 - downstream may use high near 228 and low near 64 for gain
// RL6 - marker enabled: sample LSB replaced by sampled marker input
// RL7 - marker delayed to match data latency, upper 11 bits plus marker
// RL8 - in 8-bit modes the marker goes in the 8-bit sample LSB
// RL9 - marker input is asynchronous and is synchronised before use
// RL10 - marker insertion never used in decimation modes
// RL11 - dual mode one sample per clock, single mode two per clock
// RL12 - flag clears at next window unless threshold is exceeded again
`timescale 1ns/1ns
`default_nettype none
`include "sfi_consts.vh"

module sfi_top (
  input wire clk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire [11:0] conv_samp_a,
  input wire [11:0] conv_samp_b,
  input wire [15:0] ddc_a_i,
  input wire [15:0] ddc_a_q,
  input wire [15:0] ddc_b_i,
  input wire [15:0] ddc_b_q,
  input wire ddc_valid,
  input wire external_marker_input,
  output reg [15:0] out_a_i,
  output reg [15:0] out_a_q,
  output reg [15:0] out_b_i,
  output reg [15:0] out_b_q,
  output reg out_valid,
  output reg irq
);

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  reg [3:0] ctrl_q;
  reg [7:0] high_overrange_threshold_q;
  reg [7:0] low_overrange_threshold_q;
  reg [3:0] overrange_period_exponent_q;
  reg [5:0] status_q;
  reg [5:0] enable_q;

  wire marker_en = ctrl_q[`SFI_CTRL_MARKER_EN];
  wire single_mode = ctrl_q[`SFI_CTRL_SINGLE];
  wire decim_mode = ctrl_q[`SFI_CTRL_DECIM];
  wire eight_bit = ctrl_q[`SFI_CTRL_EIGHT_BIT];
  // link_format_select is the mode field of the control register
  wire [2:0] link_format_select = ctrl_q[3:1];

  wire wr_ctrl = reg_wr && (reg_addr == `SFI_REG_CTRL);
  wire wr_thr = reg_wr && (reg_addr == `SFI_REG_THRESH);
  wire wr_per = reg_wr && (reg_addr == `SFI_REG_PERIOD);
  wire wr_clr = reg_wr && (reg_addr == `SFI_REG_CLEAR);
  wire wr_en = reg_wr && (reg_addr == `SFI_REG_ENABLE);

  // control, threshold, period and enable writes
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_q <= `SFI_CTRL_RST;
      high_overrange_threshold_q <= `SFI_THR_HI_RST;
      low_overrange_threshold_q <= `SFI_THR_LO_RST;
      overrange_period_exponent_q <= `SFI_PER_RST;
      enable_q <= `SFI_ST_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_q <= reg_wdata[3:0];
      end
      if (wr_thr)
      begin
        high_overrange_threshold_q <= reg_wdata[`SFI_THR_HI_LSB +: 8];
        low_overrange_threshold_q <= reg_wdata[`SFI_THR_LO_LSB +: 8];
      end
      if (wr_per)
      begin
        overrange_period_exponent_q <= reg_wdata[3:0];
      end
      if (wr_en)
      begin
        enable_q <= reg_wdata[5:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // windowed overrange detectors, one per channel
  // ----------------------------------------------------------------
  wire chan_a_high_flag;
  wire chan_a_low_flag;
  wire chan_b_high_flag;
  wire chan_b_low_flag;

  // in single mode each lane carries half the samples of one channel
  sfi_ovr_win u_win_a (
    .clk(clk),
    .reset_n(reset_n),
    .sample(conv_samp_a),
    .two_per_clk(single_mode),
    .thr_hi(high_overrange_threshold_q),
    .thr_lo(low_overrange_threshold_q),
    .period_exp(overrange_period_exponent_q),
    .hi_flag(chan_a_high_flag),
    .lo_flag(chan_a_low_flag)
  );

  sfi_ovr_win u_win_b (
    .clk(clk),
    .reset_n(reset_n),
    .sample(conv_samp_b),
    .two_per_clk(single_mode),
    .thr_hi(high_overrange_threshold_q),
    .thr_lo(low_overrange_threshold_q),
    .period_exp(overrange_period_exponent_q),
    .hi_flag(chan_b_high_flag),
    .lo_flag(chan_b_low_flag)
  );

  // ----------------------------------------------------------------
  // marker synchroniser
  // ----------------------------------------------------------------
  reg mrk_meta_q;
  reg mrk_sync_q;

  // two flops; only the second is used downstream
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mrk_meta_q <= 1'b0;
      mrk_sync_q <= 1'b0;
    end
    else
    begin
      mrk_meta_q <= external_marker_input; // RL9
      mrk_sync_q <= mrk_meta_q; // RL9
    end
  end

  // ----------------------------------------------------------------
  // converter sample delay to match the marker path
  // ----------------------------------------------------------------
  reg [11:0] dly_a_q [0:1];
  reg [11:0] dly_b_q [0:1];
  integer i;

  // two stages, same depth as the synchroniser
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (i = 0; i < `SFI_MRK_LAT; i = i + 1)
      begin
        dly_a_q[i] <= 12'h000;
        dly_b_q[i] <= 12'h000;
      end
    end
    else
    begin
      dly_a_q[0] <= conv_samp_a; // RL7
      dly_b_q[0] <= conv_samp_b; // RL7
      for (i = 1; i < `SFI_MRK_LAT; i = i + 1)
      begin
        dly_a_q[i] <= dly_a_q[i-1];
        dly_b_q[i] <= dly_b_q[i-1];
      end
    end
  end

  wire [11:0] al_a = dly_a_q[`SFI_MRK_LAT-1];
  wire [11:0] al_b = dly_b_q[`SFI_MRK_LAT-1];
  // marker is never inserted while decimating
  wire mrk_use = marker_en && !decim_mode; // RL10

  // ----------------------------------------------------------------
  // output sample assembly
  // ----------------------------------------------------------------
  reg [15:0] a_i_d;
  reg [15:0] a_q_d;
  reg [15:0] b_i_d;
  reg [15:0] b_q_d;
  reg valid_d;

  // choose between embedded flags, marker and plain samples
  always @*
  begin
    a_i_d = 16'h0000;
    a_q_d = 16'h0000;
    b_i_d = 16'h0000;
    b_q_d = 16'h0000;
    valid_d = 1'b1;
    if (decim_mode)
    begin
      a_i_d = {ddc_a_i[15:1], chan_a_high_flag}; // RL3 RL4
      a_q_d = {ddc_a_q[15:1], chan_a_low_flag}; // RL3 RL4
      b_i_d = {ddc_b_i[15:1], chan_b_high_flag}; // RL3 RL4
      b_q_d = {ddc_b_q[15:1], chan_b_low_flag}; // RL3 RL4
      valid_d = ddc_valid;
    end
    else if (eight_bit)
    begin
      // eight-bit samples sit in the low byte
      a_i_d = {8'h00, al_a[11:5], mrk_use ? mrk_sync_q : al_a[4]}; // RL8
      b_i_d = {8'h00, al_b[11:5], mrk_use ? mrk_sync_q : al_b[4]}; // RL8
    end
    else
    begin
      a_i_d = {4'h0, al_a[11:1], mrk_use ? mrk_sync_q : al_a[0]}; // RL6 RL7
      b_i_d = {4'h0, al_b[11:1], mrk_use ? mrk_sync_q : al_b[0]}; // RL6 RL7
    end
  end

  // output registers
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_a_i <= 16'h0000;
      out_a_q <= 16'h0000;
      out_b_i <= 16'h0000;
      out_b_q <= 16'h0000;
      out_valid <= 1'b0;
    end
    else
    begin
      out_a_i <= a_i_d;
      out_a_q <= a_q_d;
      out_b_i <= b_i_d;
      out_b_q <= b_q_d;
      out_valid <= valid_d;
    end
  end

  // ----------------------------------------------------------------
  // event detection for the interrupt status
  // ----------------------------------------------------------------
  reg [3:0] flags_prev_q;
  reg mrk_prev_q;
  wire [3:0] flags_now = {chan_b_low_flag, chan_b_high_flag,
    chan_a_low_flag, chan_a_high_flag};
  wire [5:0] events;

  // rising flags, rising marker, marker asked for while decimating
  assign events[3:0] = flags_now & ~flags_prev_q;
  assign events[`SFI_ST_MARKER] = mrk_use && mrk_sync_q && !mrk_prev_q;
  assign events[`SFI_ST_REFUSED] = marker_en && decim_mode; // RL10

  // previous values for edge detection
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flags_prev_q <= 4'h0;
      mrk_prev_q <= 1'b0;
    end
    else
    begin
      flags_prev_q <= flags_now;
      mrk_prev_q <= mrk_sync_q;
    end
  end

  // sticky status; a new event wins over a clear in the same cycle
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_q <= `SFI_ST_RST;
    end
    else if (wr_clr)
    begin
      status_q <= (status_q & ~reg_wdata[5:0]) | events;
    end
    else
    begin
      status_q <= status_q | events;
    end
  end

  // level interrupt while an enabled status bit is set
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(status_q & enable_q);
    end
  end

  // ----------------------------------------------------------------
  // register read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  reg [31:0] rd_mux;

  // unmapped and write-only offsets read as zero
  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      `SFI_REG_CTRL:
        rd_mux = {28'h000_0000, ctrl_q};
      `SFI_REG_THRESH:
        rd_mux = {16'h0000, low_overrange_threshold_q,
          high_overrange_threshold_q};
      `SFI_REG_PERIOD:
        rd_mux = {28'h000_0000, overrange_period_exponent_q};
      `SFI_REG_STATUS:
        rd_mux = {26'h000_0000, status_q};
      `SFI_REG_ENABLE:
        rd_mux = {26'h000_0000, enable_q};
      `SFI_REG_FLAGS:
        rd_mux = {25'h000_0000, link_format_select, flags_now};
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end

  // read data register, zero when no read was made
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else if (reg_rd)
    begin
      reg_rdata <= rd_mux;
    end
    else
    begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // sfi_top

`default_nettype wire

// *** sfi_top_properties.sv ***
// checker for sfi_top: port-level timing of registers, samples and irq
// assumes: bound to sfi_top, one clock domain, control tracked from bus writes
`timescale 1ns/1ns
`default_nettype none
`include "sfi_consts.vh"
module sfi_top_properties (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [11:0] conv_samp_a,
  input wire logic [11:0] conv_samp_b,
  input wire logic [15:0] ddc_a_i,
  input wire logic [15:0] ddc_b_q,
  input wire logic ddc_valid,
  input wire logic external_marker_input,
  input wire logic [15:0] out_a_i,
  input wire logic [15:0] out_a_q,
  input wire logic [15:0] out_b_i,
  input wire logic [15:0] out_b_q,
  input wire logic out_valid,
  input wire logic irq
);
  logic [3:0] ctrl_q;
  logic [2:0] cnt_q;
  wire logic wr_ctrl = reg_wr && reg_addr == `SFI_REG_CTRL;
  wire logic ok = cnt_q == 3'h5 && !wr_ctrl;

  // ---------------------------------------------------------------
  // mode shadow and quiet-cycle count after a mode change
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_q <= 4'h0;
      cnt_q <= 3'h0;
    end
    else if (wr_ctrl)
    begin
      ctrl_q <= reg_wdata[3:0];
      cnt_q <= 3'h0;
    end
    else if (cnt_q != 3'h5)
      cnt_q <= cnt_q + 3'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  property p_irq_off;
    reg_wr && reg_addr == `SFI_REG_ENABLE && reg_wdata[5:0] == 6'h00 |-> ##2 !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq stays with all masked");
  property p_decim;
    ok && ctrl_q[2] |=> out_a_i[15:1] == $past(ddc_a_i[15:1])
      && out_b_q[15:1] == $past(ddc_b_q[15:1]) && out_valid == $past(ddc_valid);
  endproperty
  a_decim: assert property (p_decim) else $error("decim word wrong");
  property p_bits12;
    ok && ctrl_q[3:2] == 2'b00 |-> out_a_i[15:1] == {4'h0, $past(conv_samp_a[11:1], 3)};
  endproperty
  a_bits12: assert property (p_bits12) else $error("12-bit word wrong");
  property p_bits8;
    ok && ctrl_q[3:2] == 2'b10 |-> out_b_i[15:1] == {8'h00, $past(conv_samp_b[11:5], 3)};
  endproperty
  a_bits8: assert property (p_bits8) else $error("8-bit word wrong");
  property p_marker;
    ok && ctrl_q[0] && !ctrl_q[2] |-> out_a_i[0] == $past(external_marker_input, 3);
  endproperty
  a_marker: assert property (p_marker) else $error("marker bit misaligned");
  property p_own_bit;
    ok && ctrl_q == 4'h0 |-> out_b_i[0] == $past(conv_samp_b[0], 3);
  endproperty
  a_own_bit: assert property (p_own_bit) else $error("sample lsb lost");
  property p_stream;
    ok && !ctrl_q[2] |-> out_valid && out_a_q == 16'h0000 && out_b_q == 16'h0000;
  endproperty
  a_stream: assert property (p_stream) else $error("stream word missing");

  c_decim: cover property (ok && ctrl_q[2] && ddc_valid);
  c_marker: cover property (ok && ctrl_q[0] && external_marker_input);
  c_irq: cover property ($rose(irq));
endmodule // sfi_top_properties

bind sfi_top sfi_top_properties u_props (.clk(clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .conv_samp_a(conv_samp_a), .conv_samp_b(conv_samp_b),
  .ddc_a_i(ddc_a_i), .ddc_b_q(ddc_b_q), .ddc_valid(ddc_valid),
  .external_marker_input(external_marker_input), .out_a_i(out_a_i), .out_a_q(out_a_q),
  .out_b_i(out_b_i), .out_b_q(out_b_q), .out_valid(out_valid), .irq(irq));
`default_nettype wire

// *** sfi_link_rx.sv ***
// downstream receiver model: takes valid words, turns high flags into gain
// assumes: words arrive on clk with word_valid, high flag in the i lsb
`timescale 1ns/1ns
`default_nettype none
module sfi_link_rx (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic word_valid,
  input wire logic [15:0] a_i,
  input wire logic [15:0] b_i,
  output logic gain_down
);
  // high flag on either lane asks for less gain
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      gain_down <= 1'b0;
    else if (word_valid)
      gain_down <= a_i[0] | b_i[0];
  end
endmodule // sfi_link_rx
`default_nettype wire

// *** test_sfi_top.sv ***
// testbench for sfi_top: register tasks, stream model, flags and irq
// assumes: sfi_top, sfi_link_rx and the bound checker compiled before
`timescale 1ns/1ns
`default_nettype none
`include "sfi_consts.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module test_sfi_top;
  logic clk, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, mrk = 1'b0, dv = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, rv;
  logic [11:0] sa = 12'h000, sb = 12'h000, fix_a, fix_b;
  logic [15:0] ai = 16'h0000, aq = 16'h0000, bi = 16'h0000, bq = 16'h0000;
  logic [15:0] o_ai, o_aq, o_bi, o_bq;
  logic out_valid, irq, gain_down, fixed = 1'b0, fa_hi, fa_lo, fb_hi, fb_lo;
  logic [24:0] h [0:3];
  logic [64:0] d [0:1];
  logic [3:0] ctrl = 4'h0;
  logic [31:0] modes [0:6] = '{0, 1, 2, 3, 8, 9, 11};
  logic [11:0] ta [0:2] = '{12'h200, 12'h800, 12'h71F};
  logic [11:0] tb [0:2] = '{12'h1FF, 12'h8E0, 12'h000};
  int errors = 0, n_checks = 0, settle = 0, cycles = 0, seed;

  sfi_top dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_samp_a(sa),
    .conv_samp_b(sb), .ddc_a_i(ai), .ddc_a_q(aq), .ddc_b_i(bi), .ddc_b_q(bq),
    .ddc_valid(dv), .external_marker_input(mrk), .out_a_i(o_ai), .out_a_q(o_aq),
    .out_b_i(o_bi), .out_b_q(o_bq), .out_valid(out_valid), .irq(irq));
  sfi_link_rx rx (.clk(clk), .reset_n(reset_n), .word_valid(out_valid), .a_i(o_ai),
    .b_i(o_bi), .gain_down(gain_down));

  // ---------------------------------------------------------------
  // model of the output words
  // ---------------------------------------------------------------
  function automatic logic [15:0] lane(input logic [11:0] s, input logic m);
    logic b;
    b = ctrl[0] ? m : (ctrl[3] ? s[4] : s[0]);
    lane = ctrl[3] ? {8'h00, s[11:5], b} : {4'h0, s[11:1], b};
  endfunction
  function automatic logic over(input logic [11:0] s, input logic [7:0] t);
    logic [10:0] m;
    m = s[11] ? (s == 12'h800 ? 11'h7FF : 11'(-s)) : s[10:0];
    over = m[10:3] >= t;
  endfunction

  task automatic setfix(input logic [11:0] a, input logic [11:0] b);
    fix_a = a;
    fix_b = b;
    fixed = 1'b1;
    settle = 0;
    fa_hi = over(a, `SFI_THR_HI_RST);
    fa_lo = over(a, `SFI_THR_LO_RST);
    fb_hi = over(b, `SFI_THR_HI_RST);
    fb_lo = over(b, `SFI_THR_LO_RST);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == `SFI_REG_CTRL)
      ctrl = v[3:0];
    settle = 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    rv = reg_rdata;
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // cycle ceiling, about five times the expected run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 5000)
    begin
      errors++;
      test_done();
    end
  end

  // drive samples each edge and compare settled outputs with the model
  always @(posedge clk)
  begin
    if (settle > 40 && !ctrl[2])
    begin
      `CHK(o_ai, lane(h[3][11:0], h[3][24]))
      `CHK(o_bi, lane(h[3][23:12], h[3][24]))
    end
    if (settle > 40 && ctrl[2])
    begin
      `CHK(({o_ai, o_aq}), ({d[1][63:49], fa_hi, d[1][47:33], fa_lo}))
      `CHK(({o_bi, o_bq, out_valid}), ({d[1][31:17], fb_hi, d[1][15:1], fb_lo, d[1][64]}))
    end
    h[3] = h[2];
    h[2] = h[1];
    h[1] = h[0];
    h[0] = 25'({$random(seed), $random(seed)});
    if (fixed)
      h[0][23:0] = {fix_b, fix_a};
    d[1] = d[0];
    d[0] = 65'({$random(seed), $random(seed), $random(seed)});
    {mrk, sb, sa} <= h[0];
    {dv, ai, aq, bi, bq} <= d[0];
    settle++;
  end

  initial
  begin
    seed = 32'h730f;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(`SFI_REG_THRESH);
    `CHK(rv, 32'h0000_40E4)
    rd(8'h40);
    `CHK(rv, 32'h0000_0000)
    foreach (modes[i])
    begin
      wr(`SFI_REG_CTRL, modes[i]);
      repeat (80) @(posedge clk);
    end
    // embedded flags at and around both thresholds
    wr(`SFI_REG_CTRL, 32'h0000_0004);
    foreach (ta[i])
    begin
      setfix(ta[i], tb[i]);
      repeat (60) @(posedge clk);
      rd(`SFI_REG_FLAGS);
      `CHK(rv, ({25'h0, 3'b010, fb_lo, fb_hi, fa_lo, fa_hi}))
      `CHK(gain_down, fa_hi | fb_hi)
    end
    // one-sample spike inside a window of eight
    setfix(12'h000, 12'h000);
    wr(`SFI_REG_PERIOD, 32'h0000_0003);
    repeat (30) @(posedge clk);
    wr(`SFI_REG_CLEAR, 32'h0000_003F);
    wr(`SFI_REG_ENABLE, 32'h0000_0001);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    setfix(12'h7FF, 12'h000);
    @(posedge clk);
    setfix(12'h000, 12'h000);
    repeat (30) @(posedge clk);
    rd(`SFI_REG_STATUS);
    `CHK(rv[0], 1'b1)
    rd(`SFI_REG_FLAGS);
    `CHK(rv[0], 1'b0)
    `CHK(irq, 1'b1)
    wr(`SFI_REG_ENABLE, 32'h0000_0000);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    wr(`SFI_REG_ENABLE, 32'h0000_0001);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    wr(`SFI_REG_CLEAR, 32'h0000_0001);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    // marker asked for while decimating is refused
    wr(`SFI_REG_CTRL, 32'h0000_0005);
    repeat (50) @(posedge clk);
    rd(`SFI_REG_STATUS);
    `CHK(rv[5:4], 2'b10)
    test_done();
  end
endmodule // test_sfi_top
`default_nettype wire
